// ---- logic/pss_sram_port.sv ----
// Pipelined burst SRAM port: input registers, burst counter, self-timed write, pipelined read
// How it works
// - Every synchronous input is registered on the rising edge of the single clock.
// - Address and chip selects load only when either address strobe is low.
// - A two-bit counter supplies the low address bits of each burst word.
// - Burst addresses after the first come from the counter, stepped by burst advance.
// - The counter runs in interleaved or linear order as the order input selects.
// - Address, data and write controls are registered and the array write completes alone.
// - Lane write selects decide which of the four byte lanes are written, each lane on its own.
// - An asserted all-lanes write writes every lane whatever the lane controls say.
// - Output enable and sleep act without the clock.
// - Reads are pipelined: first word three clocks after the address, then one per clock.
// - A registered deselect takes effect within one clock.
// - The two lowest address bits are the counter's starting value.
// - The device is selected only with depth select high and both other selects low.
// - After a deselected state, output enable is ignored on the first clock of a read.
`timescale 1ns/1ns
module pss_sram_port
    import pss_pkg::*;
#(
    parameter int DEPTH = 1024
)(
    input  wire logic                   ref_clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic [pss_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                   processor_address_strobe_n_i,
    input  wire logic                   controller_address_strobe_n_i,
    input  wire logic                   burst_advance_n_i,
    input  wire logic                   pipeline_select_n_i,
    input  wire logic                   depth_select_high_i,
    input  wire logic                   depth_select_low_n_i,
    input  wire logic                   all_lanes_write_n_i,
    input  wire logic                   lane_write_enable_n_i,
    input  wire logic [pss_pkg::LANES-1:0] lane_write_select_n_i,
    input  wire pss_pkg::pss_order_t    burst_order_i,
    input  wire logic                   output_enable_n_i,
    input  wire logic                   sleep_request_i,
    input  wire logic [pss_pkg::DATA_W-1:0] data_i,
    output logic [pss_pkg::DATA_W-1:0]  data_o,
    output logic                        data_oe_n_o,
    output logic                        rd_valid_o,
    input  wire logic                   rd_ready_i
);
    import pss_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);
    initial begin
        if (DEPTH < 4 || DEPTH > (1 << ADDR_W) || (DEPTH & (DEPTH - 1)) != 0)
            $error("DEPTH must be a power of two from 4 to 2**ADDR_W");
    end

    logic [DATA_W-1:0]  mem [DEPTH];
    logic [ADDR_W-1:0]  base_reg;
    logic [BURST_W-1:0] cnt_reg;
    logic [BURST_W-1:0] start_reg;
    logic               sel_reg;
    logic               wr_reg;
    logic [LANES-1:0]   lanes_reg;
    logic [DATA_W-1:0]  wdata_reg;
    logic [ADDR_W-1:0]  waddr_reg;
    logic               rd_req_reg;
    logic [ADDR_W-1:0]  raddr_reg;
    logic               arr_vld_reg;
    logic [DATA_W-1:0]  arr_dat_reg;
    logic               first_reg;
    logic               desel_prev_reg;
    logic [DATA_W-1:0]  buf_dat_reg [2];
    logic [1:0]         buf_cnt_reg;
    logic               buf_rp_reg;
    logic               buf_wp_reg;

    logic               strobe;
    logic               selected_now;
    logic               load;
    logic               advance;
    logic [BURST_W-1:0] cnt_next;
    logic [ADDR_W-1:0]  cur_addr;
    logic               any_write;
    logic [LANES-1:0]   lanes_next;
    logic               buf_push;
    logic               buf_pop;
    logic               buf_ready;

    // Sequence step from burst start and step count
    function automatic logic [BURST_W-1:0] burst_step(input pss_order_t ord,
                                                      input logic [BURST_W-1:0] start,
                                                      input logic [BURST_W-1:0] step);
        if (ord == PSS_INTERLEAVED)
            burst_step = start ^ step;
        else
            burst_step = BURST_W'(start + step);
    endfunction

    // Processor strobe is ignored while pipeline select is high
    assign strobe = (!processor_address_strobe_n_i && !pipeline_select_n_i)
                  || !controller_address_strobe_n_i;
    assign selected_now = !pipeline_select_n_i && depth_select_high_i && !depth_select_low_n_i;
    assign load     = strobe;
    assign advance  = !load && sel_reg && !burst_advance_n_i;
    assign cnt_next = load ? '0 : (advance ? BURST_W'(cnt_reg + 1'b1) : cnt_reg);
    assign cur_addr = {base_reg[ADDR_W-1:BURST_W], burst_step(burst_order_i, start_reg, cnt_reg)};

    assign lanes_next = !all_lanes_write_n_i ? ~ALL_LANES_N
                      : (!lane_write_enable_n_i ? ~lane_write_select_n_i : ~NO_LANES_N);
    assign any_write  = lanes_next != '0;
    assign buf_ready  = buf_cnt_reg < 2'h2;

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            base_reg  <= '0;
            start_reg <= '0;
            cnt_reg   <= '0;
            sel_reg   <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            if (load)
            begin
                base_reg  <= addr_i;
                start_reg <= addr_i[BURST_W-1:0];
                sel_reg   <= selected_now;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_reg    <= 1'b0;
            lanes_reg <= '0;
            wdata_reg <= '0;
            waddr_reg <= '0;
        end
        else
        begin
            // Processor strobe cycle never writes, and reads only with write controls idle; write follows on later cycle
            wr_reg    <= sel_reg && !load && any_write
                      || (load && selected_now && processor_address_strobe_n_i && any_write);
            lanes_reg <= lanes_next;
            wdata_reg <= data_i;
            waddr_reg <= load ? addr_i : (advance ? {base_reg[ADDR_W-1:BURST_W],
                         burst_step(burst_order_i, start_reg, BURST_W'(cnt_reg + 1'b1))}
                         : cur_addr);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (wr_reg)
        begin
            for (int l = 0; l < LANES; l++)
                if (lanes_reg[l])
                    mem[waddr_reg[IDX_W-1:0]][l*LANE_W +: LANE_W] <= wdata_reg[l*LANE_W +: LANE_W];
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_req_reg  <= 1'b0;
            raddr_reg   <= '0;
            arr_vld_reg <= 1'b0;
            arr_dat_reg <= '0;
        end
        else if (buf_ready)
        begin
            rd_req_reg  <= load ? (selected_now && !any_write) : (advance && !any_write);
            raddr_reg   <= load ? addr_i : {base_reg[ADDR_W-1:BURST_W],
                           burst_step(burst_order_i, start_reg, cnt_next)};
            arr_vld_reg <= rd_req_reg;
            arr_dat_reg <= mem[raddr_reg[IDX_W-1:0]];
        end
    end

    // Two-entry output buffer: a stalled reader loses no word in flight; a read issued while the buffer is full is dropped
    assign buf_push = arr_vld_reg && buf_ready;
    assign buf_pop  = rd_valid_o && rd_ready_i;
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            buf_cnt_reg    <= '0;
            buf_rp_reg     <= 1'b0;
            buf_wp_reg     <= 1'b0;
            buf_dat_reg[0] <= '0;
            buf_dat_reg[1] <= '0;
        end
        else
        begin
            if (buf_push)
            begin
                buf_dat_reg[buf_wp_reg] <= arr_dat_reg;
                buf_wp_reg <= !buf_wp_reg;
            end
            if (buf_pop)
                buf_rp_reg <= !buf_rp_reg;
            buf_cnt_reg <= 2'(buf_cnt_reg + buf_push - buf_pop);
        end
    end
    assign rd_valid_o = buf_cnt_reg != '0;
    assign data_o     = buf_dat_reg[buf_rp_reg];

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            desel_prev_reg <= 1'b1;
            first_reg      <= 1'b0;
        end
        else
        begin
            desel_prev_reg <= !arr_vld_reg;
            first_reg      <= arr_vld_reg && desel_prev_reg;
        end
    end

    assign data_oe_n_o = output_enable_n_i || sleep_request_i || first_reg || !rd_valid_o;

    // Assertions
    chk_burst_wrap: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        advance |=> cur_addr[ADDR_W-1:BURST_W] == $past(cur_addr[ADDR_W-1:BURST_W]))
        else $error("burst carried into upper address");
    chk_load_strobe: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !strobe |=> base_reg == $past(base_reg))
        else $error("address loaded without strobe");
    chk_counter_reset: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        load |=> cur_addr[BURST_W-1:0] == $past(addr_i[BURST_W-1:0]))
        else $error("counter not seeded from low address");
    chk_select_decode: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        load && !depth_select_high_i |=> !sel_reg)
        else $error("selected with depth select low");
    chk_read_latency: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        rd_req_reg && buf_ready |=> arr_vld_reg)
        else $error("read pipeline stage lost");
    chk_all_lanes: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !all_lanes_write_n_i |=> lanes_reg == ~ALL_LANES_N)
        else $error("all lanes write did not select every lane");
    chk_deselect_fast: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        load && !selected_now && buf_ready |=> !rd_req_reg)
        else $error("deselect took more than one clock");
    chk_oe_async: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        output_enable_n_i |-> data_oe_n_o)
        else $error("outputs driven while output enable high");
    chk_first_mask: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        first_reg |-> data_oe_n_o)
        else $error("output enable not masked on first read clock");
    chk_buf_bound: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        buf_cnt_reg <= 2'h2)
        else $error("output buffer overflow");
    cov_burst: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        load ##1 advance [*3]);
    cov_write: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) wr_reg);
    cov_stall: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) !buf_ready);
endmodule

// ---- logic/pss_pkg.sv ----
// Constants shared by the pipelined synchronous SRAM port
package pss_pkg;
    localparam int ADDR_W       = 20;
    localparam int LANES        = 4;
    localparam int LANE_W       = 9;
    localparam int DATA_W       = 36;
    localparam int BURST_W      = 2;
    localparam int READ_LATENCY = 3;
    localparam logic [3:0] ALL_LANES_N = 4'h0;
    localparam logic [3:0] NO_LANES_N  = 4'hF;
    typedef enum logic {PSS_INTERLEAVED, PSS_LINEAR} pss_order_t;
endpackage

// ---- tb/pss_ctrl_model.sv ----
// Controller model: drives the port's synchronous inputs and notes expected read words
`timescale 1ns/1ns
module pss_ctrl_model
    import pss_pkg::*;
(
    input  wire logic                  ref_clk_i,
    output logic [pss_pkg::ADDR_W-1:0] addr_i,
    output logic                       processor_address_strobe_n_i,
    output logic                       controller_address_strobe_n_i,
    output logic                       burst_advance_n_i,
    output logic                       pipeline_select_n_i,
    output logic                       depth_select_high_i,
    output logic                       depth_select_low_n_i,
    output logic                       all_lanes_write_n_i,
    output logic                       lane_write_enable_n_i,
    output logic [pss_pkg::LANES-1:0]  lane_write_select_n_i,
    output pss_pkg::pss_order_t        burst_order_i,
    output logic [pss_pkg::DATA_W-1:0] data_i
);
    import pss_pkg::*;
    typedef struct {logic [DATA_W-1:0] d; time t;} pss_note_t;
    pss_note_t         notes [$];
    logic [DATA_W-1:0] shadow [16];
    // Idle: strobes and write controls go inactive; address and data show the inverse of their last value, never a stale copy
    task automatic idle();
        processor_address_strobe_n_i  = 1'b1;
        controller_address_strobe_n_i = 1'b1;
        burst_advance_n_i             = 1'b1;
        all_lanes_write_n_i           = 1'b1;
        lane_write_enable_n_i         = 1'b1;
        lane_write_select_n_i         = NO_LANES_N;
        addr_i                        = ~addr_i;
        data_i                        = ~data_i;
    endtask
    initial
    begin
        addr_i = '0;
        data_i = '0;
        {pipeline_select_n_i, depth_select_high_i, depth_select_low_n_i} = 3'b010;
        burst_order_i = PSS_INTERLEAVED;
        idle();
    end
    task automatic burst(input bit wr, input bit proc, input bit sel, input pss_order_t ord,
                         input logic [ADDR_W-1:0] a, input logic [3:0] ln, input bit gw,
                         input logic [DATA_W-1:0] d [4], input int n, input bit timed);
        time        t0;
        logic [3:0] ix;
        @(posedge ref_clk_i) #1;
        t0 = $time;
        burst_order_i = ord;
        for (int k = 0; k < n; k++)
        begin
            ix = {a[3:2], (ord == PSS_INTERLEAVED) ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
            processor_address_strobe_n_i  = !(k == 0 && proc);
            controller_address_strobe_n_i = !(k == 0 && !proc);
            burst_advance_n_i             = (k == 0);
            addr_i                        = (k == 0) ? a : ~addr_i;
            depth_select_high_i           = sel;
            all_lanes_write_n_i           = !(wr && gw);
            lane_write_enable_n_i         = !(wr && !gw);
            lane_write_select_n_i         = ln;
            data_i                        = wr ? d[k] : ~data_i;
            for (int l = 0; l < LANES; l++)
                if (wr && (gw || !ln[l]))
                    shadow[ix][l*LANE_W +: LANE_W] = d[k][l*LANE_W +: LANE_W];
            if (!wr && sel)
                notes.push_back('{shadow[ix], timed ? t0 + 9 + 10 * (READ_LATENCY + k) : 0});
            @(posedge ref_clk_i) #1;
        end
        depth_select_high_i = 1'b1;
        idle();
    endtask
endmodule

// ---- tb/pss_sram_port_test.sv ----
// Self-checking bench for the pipelined synchronous SRAM port
`timescale 1ns/1ns
module pss_sram_port_test;
    import pss_pkg::*;
    logic ref_clk_i = 1'b0, arst_n_i = 1'b0, rd_ready_i = 1'b1;
    logic output_enable_n_i = 1'b0, sleep_request_i = 1'b0, rd_valid_o, data_oe_n_o;
    logic                       processor_address_strobe_n_i, controller_address_strobe_n_i;
    logic                       burst_advance_n_i, pipeline_select_n_i, depth_select_high_i;
    logic                       depth_select_low_n_i, all_lanes_write_n_i, lane_write_enable_n_i;
    logic [LANES-1:0]           lane_write_select_n_i;
    logic [ADDR_W-1:0]          addr_i;
    logic [DATA_W-1:0]          data_i, data_o;
    pss_order_t                 burst_order_i;
    logic [DATA_W-1:0]          w [4];
    logic [3:0]                 lanes [6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h0};
    int                         n_fail = 0, n_compared = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    pss_sram_port #(
        .DEPTH (16)
    ) u_dut (
        .ref_clk_i                     (ref_clk_i),
        .arst_n_i                      (arst_n_i),
        .addr_i                        (addr_i),
        .processor_address_strobe_n_i  (processor_address_strobe_n_i),
        .controller_address_strobe_n_i (controller_address_strobe_n_i),
        .burst_advance_n_i             (burst_advance_n_i),
        .pipeline_select_n_i           (pipeline_select_n_i),
        .depth_select_high_i           (depth_select_high_i),
        .depth_select_low_n_i          (depth_select_low_n_i),
        .all_lanes_write_n_i           (all_lanes_write_n_i),
        .lane_write_enable_n_i         (lane_write_enable_n_i),
        .lane_write_select_n_i         (lane_write_select_n_i),
        .burst_order_i                 (burst_order_i),
        .output_enable_n_i             (output_enable_n_i),
        .sleep_request_i               (sleep_request_i),
        .data_i                        (data_i),
        .data_o                        (data_o),
        .data_oe_n_o                   (data_oe_n_o),
        .rd_valid_o                    (rd_valid_o),
        .rd_ready_i                    (rd_ready_i)
    );
    pss_ctrl_model u_ctrl (
        .ref_clk_i                     (ref_clk_i),
        .addr_i                        (addr_i),
        .processor_address_strobe_n_i  (processor_address_strobe_n_i),
        .controller_address_strobe_n_i (controller_address_strobe_n_i),
        .burst_advance_n_i             (burst_advance_n_i),
        .pipeline_select_n_i           (pipeline_select_n_i),
        .depth_select_high_i           (depth_select_high_i),
        .depth_select_low_n_i          (depth_select_low_n_i),
        .all_lanes_write_n_i           (all_lanes_write_n_i),
        .lane_write_enable_n_i         (lane_write_enable_n_i),
        .lane_write_select_n_i         (lane_write_select_n_i),
        .burst_order_i                 (burst_order_i),
        .data_i                        (data_i)
    );
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic randw();
        foreach (w[i]) w[i] = DATA_W'({$urandom, $urandom});
    endtask
    always @(posedge ref_clk_i)
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
        begin
            if (u_ctrl.notes.size() == 0)
                check(data_o, ~data_o);
            else
            begin
                check(data_o, u_ctrl.notes[0].d);
                if (u_ctrl.notes[0].t != 0)
                    check(DATA_W'($time), DATA_W'(u_ctrl.notes[0].t));
                void'(u_ctrl.notes.pop_front());
            end
        end
    initial
    begin
        #200000;
        n_fail++;
        final_report();
    end
    initial
    begin
        void'($urandom(32'h573bd371));
        repeat (8) @(posedge ref_clk_i);
        #1 arst_n_i = 1'b1;
        for (int o = 0; o < 2; o++)
        begin
            randw();
            output_enable_n_i = 1'b1;
            u_ctrl.burst(1, 0, 1, pss_order_t'(o), 20'(6 + 4 * o), NO_LANES_N, 1, w, 4, 0);
            output_enable_n_i = 1'b0;
            u_ctrl.burst(0, o[0], 1, pss_order_t'(o), 20'(5 + 4 * o), NO_LANES_N, 0, w, 4, 1);
        end
        output_enable_n_i = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            randw();
            u_ctrl.burst(1, 0, 1, PSS_LINEAR, 20'(4 + i), lanes[i], 0, w, 1, 0);
        end
        output_enable_n_i = 1'b0;
        u_ctrl.burst(0, 0, 1, PSS_LINEAR, 20'h4, NO_LANES_N, 0, w, 4, 1);
        u_ctrl.burst(0, 0, 0, PSS_LINEAR, 20'h8, NO_LANES_N, 0, w, 1, 1);
        u_ctrl.burst(0, 1, 1, PSS_LINEAR, 20'h9, NO_LANES_N, 0, w, 1, 1);
        repeat (6) @(posedge ref_clk_i);
        // Receiver stall: buffer fills, nothing lost
        #1 rd_ready_i = 1'b0;
        u_ctrl.burst(0, 0, 1, PSS_LINEAR, 20'h8, NO_LANES_N, 0, w, 2, 0);
        repeat (10) @(posedge ref_clk_i);
        // asynchronous output gating while a word stands, no clock edge between
        #1 output_enable_n_i = 1'b1;
        #1 check(DATA_W'(data_oe_n_o), 1);
        @(posedge ref_clk_i);
        #1 output_enable_n_i = 1'b0;
        sleep_request_i = 1'b1;
        #1 check(DATA_W'(data_oe_n_o), 1);
        @(posedge ref_clk_i);
        #1 sleep_request_i = 1'b0;
        #1 check(DATA_W'(data_oe_n_o), 0);
        @(posedge ref_clk_i);
        #1 rd_ready_i = 1'b1;
        repeat (6) @(posedge ref_clk_i);
        check(DATA_W'(u_ctrl.notes.size()), 0);
        final_report();
    end
endmodule
